// ===== rtl/amr_pkg.sv
/*
  Package for the analog front end register bank: offsets, reset values,
  field positions and selector codes.
  Assumes a byte-wide register port with 8-bit addresses.
*/
// Summary of operation
// - Input-connection bit 7 closes the link between the input ends; resets 0.
// - Negative selector upper nibble routes pins, common mode, DAC, sensor, amp, ground.
// - Positive selector lower nibble uses same map; 1010 is sensor plus.
// - Quiet amp bit 7 enables the amp, reset 0; bits 6..3 read zero.
// - Quiet amp bit 2 picks plus input: 0 external pin, 1 common mode.
// - Quiet amp bits 1 and 0 each drive a switch, 1 closed; reset open.
// - DAC code is 12 bits: high register 11..4, low register 3..0.
// - Writing the DAC low register fills only the shadow buffer.
// - Writing the DAC high register moves shadow into low, all bits together.
// - DAC control bit 7 enables the DAC, reset 0; bits 5..0 read zero.
// - DAC control bit 6 picks reference: 0 regulated output, 1 input supply.
// - Enabled DAC output is selectable for the common-mode buffer plus input.
// - Result appears in three read-only bytes, undefined after power-on.
// - With result latch on, result bytes hold and ignore new conversions.
package amr_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int DAC_W  = 12;
  localparam int RES_W  = 24;

  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [7:0] OFS_INPUT_CONNECTION_CTRL = 8'h00;
  localparam logic [7:0] OFS_AMP_CHANNEL_SELECT    = 8'h01;
  localparam logic [7:0] OFS_LOW_NOISE_AMP_CTRL    = 8'h02;
  localparam logic [7:0] OFS_DAC_CODE_LOW          = 8'h03;
  localparam logic [7:0] OFS_DAC_CODE_HIGH         = 8'h04;
  localparam logic [7:0] OFS_DAC_CONTROL           = 8'h05;
  localparam logic [7:0] OFS_RESULT_BYTE_LOW       = 8'h06;
  localparam logic [7:0] OFS_RESULT_BYTE_MID       = 8'h07;
  localparam logic [7:0] OFS_RESULT_BYTE_HIGH      = 8'h08;
  localparam logic [7:0] OFS_RESULT_LATCH_CTRL     = 8'h09;

  // ************************************************************
  // Reset values and field positions
  // ************************************************************
  localparam logic [7:0] RST_BYTE     = 8'h00;
  localparam int BIT_LINK_CLOSE       = 7;
  localparam int BIT_ROUTE_HI         = 6;
  localparam int BIT_ROUTE_LO         = 5;
  localparam int BIT_QAMP_ON          = 7;
  localparam int BIT_QAMP_PLUS_SRC    = 2;
  localparam int BIT_QAMP_SW_B        = 1;
  localparam int BIT_QAMP_SW_A        = 0;
  localparam int BIT_DAC_ON           = 7;
  localparam int BIT_DAC_REF_PICK     = 6;
  localparam int BIT_RESULT_LATCH_ON  = 0;

  // ************************************************************
  // Selector codes shared by both input ends
  // ************************************************************
  localparam logic [3:0] SEL_PIN0      = 4'h0;
  localparam logic [3:0] SEL_PIN3      = 4'h3;
  localparam logic [3:0] SEL_COMMON    = 4'h8;
  localparam logic [3:0] SEL_DAC       = 4'h9;
  localparam logic [3:0] SEL_TEMP      = 4'hA;
  localparam logic [3:0] SEL_QAMP      = 4'hB;
  localparam logic [3:0] SEL_GROUND    = 4'hF;

  typedef enum logic [2:0] {
    AMR_SRC_PIN,
    AMR_SRC_COMMON,
    AMR_SRC_DAC,
    AMR_SRC_TEMP,
    AMR_SRC_QAMP,
    AMR_SRC_GROUND,
    AMR_SRC_NONE
  } amr_src_e;

endpackage

// ===== rtl/amr_regs.sv
/*
  Register bank for the analog front end: input multiplexer, quiet amp,
  12-bit DAC code with shadowed low part, DAC control, conversion result.
  Assumes a single-cycle register port on i_clk and a conversion engine
  on the same clock presenting results with a one-cycle valid pulse.
*/
// The register addresses and the strobed register port were left to the implementer.
`timescale 1ns/1ps
module amr_regs (
  input  wire logic                       i_clk,
  input  wire logic                       i_reset_n,
  input  wire logic [amr_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [amr_pkg::DATA_W-1:0] i_wdata,
  input  wire logic                       i_wr,
  input  wire logic                       i_rd,
  output logic      [amr_pkg::DATA_W-1:0] o_rdata,
  input  wire logic [amr_pkg::RES_W-1:0]  i_result,
  input  wire logic                       i_result_valid,
  output logic                            o_input_link_close,
  output logic      [1:0]                 o_input_routing_field,
  output logic      [3:0]                 o_neg_end_selector,
  output logic      [3:0]                 o_pos_end_selector,
  output logic      [2:0]                 o_neg_end_source,
  output logic      [2:0]                 o_pos_end_source,
  output logic                            o_quiet_amp_on,
  output logic                            o_quiet_amp_plus_source,
  output logic                            o_quiet_amp_switch_b,
  output logic                            o_quiet_amp_switch_a,
  output logic      [amr_pkg::DAC_W-1:0]  o_dac_code,
  output logic                            o_dac_on,
  output logic                            o_dac_ref_pick,
  output logic                            o_dac_to_cm_buffer_ok,
  output logic                            o_result_latch_on
);
  import amr_pkg::*;

  // ************************************************************
  // Storage
  // ************************************************************
  logic [7:0] input_connection_ctrl;
  logic [7:0] amp_channel_select;
  logic [7:0] low_noise_amp_ctrl;
  logic [3:0] dac_shadow;
  logic [3:0] dac_code_low;
  logic [7:0] dac_code_high;
  logic [7:0] dac_control;
  logic [RES_W-1:0] result;
  logic       result_latch_on;

  logic wr_icc, wr_acs, wr_lna, wr_dcl, wr_dch, wr_dcc, wr_lat;
  assign wr_icc = i_wr && (i_addr == OFS_INPUT_CONNECTION_CTRL);
  assign wr_acs = i_wr && (i_addr == OFS_AMP_CHANNEL_SELECT);
  assign wr_lna = i_wr && (i_addr == OFS_LOW_NOISE_AMP_CTRL);
  assign wr_dcl = i_wr && (i_addr == OFS_DAC_CODE_LOW);
  assign wr_dch = i_wr && (i_addr == OFS_DAC_CODE_HIGH);
  assign wr_dcc = i_wr && (i_addr == OFS_DAC_CONTROL);
  assign wr_lat = i_wr && (i_addr == OFS_RESULT_LATCH_CTRL);

  // ************************************************************
  // Selector decode, shared by both ends
  // ************************************************************
  function automatic amr_src_e decode_sel(input logic [3:0] code);
    amr_src_e s;
    s = AMR_SRC_NONE;
    if (code <= SEL_PIN3) begin
      s = AMR_SRC_PIN;
    end else if (code == SEL_COMMON) begin
      s = AMR_SRC_COMMON;
    end else if (code == SEL_DAC) begin
      s = AMR_SRC_DAC;
    end else if (code == SEL_TEMP) begin
      s = AMR_SRC_TEMP;
    end else if (code == SEL_QAMP) begin
      s = AMR_SRC_QAMP;
    end else if (code == SEL_GROUND) begin
      s = AMR_SRC_GROUND;
    end
    return s;
  endfunction

  // ************************************************************
  // Control registers
  // ************************************************************
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      input_connection_ctrl <= RST_BYTE;
    end else if (wr_icc) begin
      // Only bits 7..5 exist; the rest stay zero
      input_connection_ctrl <= {i_wdata[7:5], 5'h00};
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      amp_channel_select <= RST_BYTE;
    end else if (wr_acs) begin
      amp_channel_select <= i_wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      low_noise_amp_ctrl <= RST_BYTE;
    end else if (wr_lna) begin
      low_noise_amp_ctrl <= {i_wdata[7], 4'h0, i_wdata[2:0]};
    end
  end

  // Shadow low nibble; live only after a high-byte write
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      dac_shadow <= 4'h0;
    end else if (wr_dcl) begin
      dac_shadow <= i_wdata[3:0];
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      dac_code_high <= RST_BYTE;
      dac_code_low  <= 4'h0;
    end else if (wr_dch) begin
      dac_code_high <= i_wdata;
      dac_code_low  <= dac_shadow;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      dac_control <= RST_BYTE;
    end else if (wr_dcc) begin
      dac_control <= {i_wdata[7:6], 6'h00};
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      result_latch_on <= 1'b0;
    end else if (wr_lat) begin
      result_latch_on <= i_wdata[BIT_RESULT_LATCH_ON];
    end
  end

  // Result has no reset: undefined after power-on
  always_ff @(posedge i_clk) begin
    if (i_result_valid && !result_latch_on) begin
      result <= i_result;
    end
  end

  // ************************************************************
  // Read port
  // ************************************************************
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rdata <= RST_BYTE;
    end else if (i_rd) begin
      unique case (i_addr)
        OFS_INPUT_CONNECTION_CTRL: o_rdata <= input_connection_ctrl;
        OFS_AMP_CHANNEL_SELECT:    o_rdata <= amp_channel_select;
        OFS_LOW_NOISE_AMP_CTRL:    o_rdata <= low_noise_amp_ctrl;
        OFS_DAC_CODE_LOW:          o_rdata <= {4'h0, dac_code_low};
        OFS_DAC_CODE_HIGH:         o_rdata <= dac_code_high;
        OFS_DAC_CONTROL:           o_rdata <= dac_control;
        OFS_RESULT_BYTE_LOW:       o_rdata <= result[7:0];
        OFS_RESULT_BYTE_MID:       o_rdata <= result[15:8];
        OFS_RESULT_BYTE_HIGH:      o_rdata <= result[23:16];
        OFS_RESULT_LATCH_CTRL:     o_rdata <= {7'h00, result_latch_on};
        default:                   o_rdata <= RST_BYTE;
      endcase
    end else begin
      o_rdata <= RST_BYTE;
    end
  end

  // ************************************************************
  // Analog control outputs, registered
  // ************************************************************
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_input_link_close      <= 1'b0;
      o_input_routing_field   <= 2'h0;
      o_neg_end_selector      <= 4'h0;
      o_pos_end_selector      <= 4'h0;
      o_neg_end_source        <= 3'h0;
      o_pos_end_source        <= 3'h0;
      o_quiet_amp_on          <= 1'b0;
      o_quiet_amp_plus_source <= 1'b0;
      o_quiet_amp_switch_b    <= 1'b0;
      o_quiet_amp_switch_a    <= 1'b0;
      o_dac_code              <= 12'h000;
      o_dac_on                <= 1'b0;
      o_dac_ref_pick          <= 1'b0;
      o_dac_to_cm_buffer_ok   <= 1'b0;
      o_result_latch_on       <= 1'b0;
    end else begin
      o_input_link_close      <= input_connection_ctrl[BIT_LINK_CLOSE];
      o_input_routing_field   <=
        input_connection_ctrl[BIT_ROUTE_HI:BIT_ROUTE_LO];
      o_neg_end_selector      <= amp_channel_select[7:4];
      o_pos_end_selector      <= amp_channel_select[3:0];
      o_neg_end_source        <= decode_sel(amp_channel_select[7:4]);
      o_pos_end_source        <= decode_sel(amp_channel_select[3:0]);
      o_quiet_amp_on          <= low_noise_amp_ctrl[BIT_QAMP_ON];
      o_quiet_amp_plus_source <=
        low_noise_amp_ctrl[BIT_QAMP_PLUS_SRC];
      o_quiet_amp_switch_b    <= low_noise_amp_ctrl[BIT_QAMP_SW_B];
      o_quiet_amp_switch_a    <= low_noise_amp_ctrl[BIT_QAMP_SW_A];
      o_dac_code              <= {dac_code_high, dac_code_low};
      o_dac_on                <= dac_control[BIT_DAC_ON];
      o_dac_ref_pick          <= dac_control[BIT_DAC_REF_PICK];
      o_dac_to_cm_buffer_ok   <= dac_control[BIT_DAC_ON];
      o_result_latch_on       <= result_latch_on;
    end
  end

endmodule

// ===== verif/amr_regs_props.sv
/* Checker for the analog front end register bank, bound to amr_regs.
   Assumes one clock and an active-low asynchronous reset. */
`timescale 1ns/1ps
module amr_regs_chk (
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  input  wire logic [7:0]  i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  input  wire logic [7:0]  o_rdata,
  input  wire logic        o_input_link_close,
  input  wire logic [3:0]  o_neg_end_selector,
  input  wire logic [3:0]  o_pos_end_selector,
  input  wire logic [2:0]  o_pos_end_source,
  input  wire logic        o_quiet_amp_on,
  input  wire logic [11:0] o_dac_code,
  input  wire logic        o_dac_on,
  input  wire logic        o_dac_ref_pick,
  input  wire logic        o_dac_to_cm_buffer_ok
);
  import amr_pkg::*;
  logic [9:0] w;
  logic [9:0] r;
  // One-hot write and read decode of the offsets 00..09
  assign w = i_wr ? 10'h001 << i_addr : 10'h000;
  assign r = i_rd ? 10'h001 << i_addr : 10'h000;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);
  a_link_follows: assert property (
    w[0] |=> ##1 o_input_link_close == $past(i_wdata[7], 2))
    else $error("link bit does not follow write");
  a_sel_follows: assert property (
    w[1] |=> ##1 {o_neg_end_selector, o_pos_end_selector} == $past(i_wdata, 2))
    else $error("selectors do not follow write");
  a_pos_common: assert property (
    o_pos_end_selector == SEL_COMMON |-> o_pos_end_source == AMR_SRC_COMMON)
    else $error("common mode code not decoded");
  a_qamp_on: assert property (
    w[2] |=> ##1 o_quiet_amp_on == $past(i_wdata[7], 2))
    else $error("quiet amp enable does not follow write");
  a_qamp_gap: assert property (
    r[2] |=> o_rdata[6:3] == 4'h0)
    else $error("quiet amp gap bits not zero");
  a_dac_shadow: assert property (
    w[3] |=> ##1 $stable(o_dac_code))
    else $error("low write changed active code");
  a_dac_commit: assert property (
    w[4] |=> ##1 o_dac_code[11:4] == $past(i_wdata, 2))
    else $error("high write not committed");
  a_dac_ctrl: assert property (
    w[5] |=> ##1 {o_dac_on, o_dac_ref_pick} == $past(i_wdata[7:6], 2))
    else $error("dac control does not follow write");
  a_dac_gap: assert property (
    r[5] |=> o_rdata[5:0] == 6'h00)
    else $error("dac control gap bits not zero");
  a_cm_path: assert property (
    o_dac_to_cm_buffer_ok == o_dac_on)
    else $error("buffer path differs from dac enable");
endmodule
bind amr_regs amr_regs_chk u_chk (.*);

// ===== verif/amr_regs_tb_top.sv
/* Self-checking bench for amr_regs with a behavioural register model.
   Assumes the checker file is compiled alongside. */
`timescale 1ns/1ps
module amr_regs_tb_top;
  import amr_pkg::*;
  logic        i_clk = 1'b0, i_reset_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
  logic        i_result_valid = 1'b0;
  logic [7:0]  i_addr = 8'h00, i_wdata = 8'h00, o_rdata;
  logic [23:0] i_result = 24'h000000, rm;
  logic [11:0] o_dac_code;
  logic [3:0]  o_neg_end_selector, o_pos_end_selector, shadow;
  logic [2:0]  o_neg_end_source, o_pos_end_source;
  logic [1:0]  o_input_routing_field;
  logic        o_input_link_close, o_quiet_amp_on, o_quiet_amp_plus_source;
  logic        o_quiet_amp_switch_b, o_quiet_amp_switch_a, o_dac_on;
  logic        o_dac_ref_pick, o_dac_to_cm_buffer_ok, o_result_latch_on;
  logic [7:0]  m [0:9];
  int          fails = 0, cmp_count = 0;
  always #5 i_clk = ~i_clk;
  amr_regs dut (.*);
  task automatic chk(input string n, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %0h seen %0h", n, e, g);
    end
  endtask
  function automatic amr_src_e src(input logic [3:0] c);
    case (c)
      4'h0, 4'h1, 4'h2, 4'h3: return AMR_SRC_PIN;
      4'h8: return AMR_SRC_COMMON;
      4'h9: return AMR_SRC_DAC;
      4'hA: return AMR_SRC_TEMP;
      4'hB: return AMR_SRC_QAMP;
      4'hF: return AMR_SRC_GROUND;
      default: return AMR_SRC_NONE;
    endcase
  endfunction
  task automatic wr(input logic [7:0] a, d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
    case (a)
      8'h00: m[0] = d & 8'hE0;
      8'h01: m[1] = d;
      8'h02: m[2] = d & 8'h87;
      8'h03: shadow = d[3:0];
      8'h04: begin
        m[4] = d;
        m[3] = {4'h0, shadow};
      end
      8'h05: m[5] = d & 8'hC0;
      8'h09: m[9] = d & 8'h01;
      default: ;
    endcase
    @(posedge i_clk);
  endtask
  task automatic rd(input logic [7:0] a);
    logic [7:0] e;
    case (a)
      8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h09: e = m[a[3:0]];
      8'h06: e = rm[7:0];
      8'h07: e = rm[15:8];
      8'h08: e = rm[23:16];
      default: e = 8'h00;
    endcase
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk("rdata", e, o_rdata);
    @(posedge i_clk);
  endtask
  task automatic co();
    #1 chk("link", m[0][7:5], {o_input_link_close, o_input_routing_field});
    chk("sel", m[1], {o_neg_end_selector, o_pos_end_selector});
    chk("src", {src(m[1][7:4]), src(m[1][3:0])},
        {o_neg_end_source, o_pos_end_source});
    chk("qamp", {m[2][7], m[2][2:0]}, {o_quiet_amp_on, o_quiet_amp_plus_source,
        o_quiet_amp_switch_b, o_quiet_amp_switch_a});
    chk("code", {m[4], m[3][3:0]}, o_dac_code);
    chk("ctrl", {m[5][7:6], m[5][7], m[9][0]}, {o_dac_on, o_dac_ref_pick,
        o_dac_to_cm_buffer_ok, o_result_latch_on});
    @(posedge i_clk);
  endtask
  task automatic res(input logic [23:0] v);
    i_result <= v;
    i_result_valid <= 1'b1;
    @(posedge i_clk);
    i_result_valid <= 1'b0;
    if (m[9][0] === 1'b0)
      rm = v;
    @(posedge i_clk);
  endtask
  task automatic stop_test();
    if (fails == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge i_clk);
    fails++;
    stop_test();
  end
  initial begin
    void'($urandom(39582));
    foreach (m[k]) m[k] = 8'h00;
    shadow = 4'h0;
    repeat (20) @(posedge i_clk);
    i_reset_n <= 1'b1;
    @(posedge i_clk);
    co();
    for (int k = 0; k < 12; k++) if (k < 6 || k > 8) rd(8'(k));
    rd(8'hFF);
    // Latch off, on, off: the middle result must be ignored
    for (int j = 0; j < 3; j++) begin
      wr(8'h09, 8'(j == 1));
      res(24'($urandom));
      for (int k = 6; k < 9; k++) rd(8'(k));
    end
    for (int c = 0; c < 16; c++) begin
      wr(8'h01, {4'(c), 4'(15 - c)});
      co();
    end
    wr(8'h03, 8'hF5);
    co();
    rd(8'h03);
    wr(8'h04, 8'hA7);
    co();
    // Single-ended use: the other end sits on common mode
    wr(8'h01, {4'h2, SEL_COMMON});
    co();
    wr(8'h01, {SEL_COMMON, 4'h1});
    co();
    // Sensor minus on the negative end is paired with sensor plus
    wr(8'h01, {SEL_TEMP, SEL_TEMP});
    co();
    repeat (80) begin
      wr(8'($urandom % 12), 8'($urandom));
      co();
      rd(8'($urandom % 12));
    end
    stop_test();
  end
endmodule
